//--- logic/reo_map.svh
// Constants for the rail enable override register bank: offsets, reset
// values, field positions and rail indices. Definitions only.
`ifndef REO_MAP_SVH
`define REO_MAP_SVH

// Register offsets on the serial bus
`define REO_SW_DIS_OFFSET 8'h9f
`define REO_OVR_ONE_OFFSET 8'ha0

// Reset values
`define REO_SW_DIS_RESET 8'h00
`define REO_OVR_ONE_RESET 8'h80

// Disable register fields
`define REO_DIS_LOAD_SWITCH_B_TWO_BIT 7
`define REO_DIS_LOAD_SWITCH_B_ONE_BIT 6
`define REO_DIS_LOAD_SWITCH_A_ONE_BIT 5
`define REO_DIS_TERM_BIT 4

// Override register fields; bits 5..0 are step-down six..one
`define REO_OVR_LOW_DROPOUT_A_TWO_BIT 7
`define REO_OVR_LOAD_SWITCH_A_ONE_BIT 6

// Rail indices in the rail vectors
`define REO_RAIL_COUNT 11
`define REO_RAIL_STEP_DOWN_BASE 0
`define REO_RAIL_LOW_DROPOUT_A_TWO 6
`define REO_RAIL_LOAD_SWITCH_A_ONE 7
`define REO_RAIL_LOAD_SWITCH_B_ONE 8
`define REO_RAIL_LOAD_SWITCH_B_TWO 9
`define REO_RAIL_TERM 10

// Serial bus framing
`define REO_BYTE_BITS 4'h8
`define REO_BIT_CNT_ZERO 4'h0
`define REO_BIT_CNT_ONE 4'h1
`define REO_PTR_STEP 8'h01
// Default 7-bit slave address, arbitrary value
`define REO_SLAVE_ADDR_DEFAULT 7'h5e

`endif

//--- logic/reo_pkg.sv
// Types for the rail enable override register bank.
// Assumes reo_map.svh is on the include path.
`include "reo_map.svh"

package reo_pkg;

    // Serial slave states, one-hot
    typedef enum logic [6:0] {
        REO_IDLE     = 7'h01,
        REO_ADDR     = 7'h02,
        REO_ACK_ADDR = 7'h04,
        REO_WR_BYTE  = 7'h08,
        REO_ACK_WR   = 7'h10,
        REO_RD_BYTE  = 7'h20,
        REO_ACK_RD   = 7'h40
    } reo_state_t;

    typedef logic [`REO_RAIL_COUNT-1:0] reo_rail_vec_t;

    // Whole state of the top module
    typedef struct packed {
        reo_state_t st;
        logic scl_prev;
        logic sda_prev;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic rw;
        logic first;
        logic nack;
        logic [7:0] ptr;
        logic drive_low;
        logic [7:0] sw_dis;
        logic [7:0] ovr_one;
        reo_rail_vec_t rail_en;
    } reo_top_state_t;

endpackage

//--- logic/reo_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are quasi-static relative to clk.
`timescale 1ns/10ps

module reo_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } reo_sync_state_t;

    localparam reo_sync_state_t SYNC_RESET = '{meta: INIT, stable: INIT};

    reo_sync_state_t s_q;
    reo_sync_state_t s_d;

    // First stage feeds only the second
    always_comb begin
        s_d = s_q;
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= SYNC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;
endmodule

//--- logic/reo_rail_gate.sv
// Enable combine for a single rail: permit AND (force OR request).
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/10ps

module reo_rail_gate (
    // Controls
    input wire logic permit,
    input wire logic force_on,
    input wire logic request,
    // Result
    output logic enable
);
    // A cleared permit bit wins over both force and request
    assign enable = permit & (force_on | request);
endmodule

//--- logic/reo_top.sv
// Rail enable override register bank with its serial (I2C) slave port.
// Assumes a sequencer on clk supplies the per-rail requests, and that
// the disable and override bits held in other registers arrive as levels.
`timescale 1ns/10ps
`include "reo_map.svh"

module reo_top #(
    parameter logic [6:0] SLAVE_ADDR = `REO_SLAVE_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial bus pins; sda is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Sequencer requests from control_input_pins / power_good_signal
    input wire reo_pkg::reo_rail_vec_t rail_request,
    // Disable bits held elsewhere, step-down one..six in bits 0..5
    input wire logic [5:0] step_down_off_ctl,
    input wire logic low_dropout_a_two_off_ctl,
    // Override bits held elsewhere
    input wire logic switch_b_one_force_on,
    input wire logic switch_b_two_force_on,
    input wire logic termination_force_on,
    // Rail enables
    output logic step_down_one_en,
    output logic step_down_two_en,
    output logic step_down_three_en,
    output logic step_down_four_en,
    output logic step_down_five_en,
    output logic step_down_six_en,
    output logic low_dropout_a_two_en,
    output logic load_switch_a_one_en,
    output logic load_switch_b_one_en,
    output logic load_switch_b_two_en,
    output logic termination_regulator_en
);
    import reo_pkg::*;

    localparam reo_top_state_t TOP_RESET = '{
        st: REO_IDLE,
        scl_prev: 1'b1,
        sda_prev: 1'b1,
        bit_cnt: `REO_BIT_CNT_ZERO,
        shift: 8'h00,
        rw: 1'b0,
        first: 1'b0,
        nack: 1'b0,
        ptr: 8'h00,
        drive_low: 1'b0,
        sw_dis: `REO_SW_DIS_RESET,
        ovr_one: `REO_OVR_ONE_RESET,
        rail_en: '0
    };

    reo_top_state_t s_q;
    reo_top_state_t s_d;

    logic scl_s;
    logic sda_s;
    reo_rail_vec_t permit;
    reo_rail_vec_t force_on;
    reo_rail_vec_t gate_out;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rd_data;
    logic [7:0] rd_next;
    logic [7:0] ptr_inc;

    // Bus pins are asynchronous: two flops before any logic
    reo_sync #(
        .WIDTH(2),
        .INIT(2'b11)
    ) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({scl_i, sda_i}),
        .sync_out({scl_s, sda_s})
    );

    // Bus events from the synchronised pins
    assign scl_rise = scl_s & ~s_q.scl_prev;
    assign scl_fall = ~scl_s & s_q.scl_prev;
    assign start_seen = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
    assign stop_seen = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;
    assign ptr_inc = s_q.ptr + `REO_PTR_STEP;

    // Register read mux; unmapped offsets read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] offs,
                                            input logic [7:0] dis,
                                            input logic [7:0] ovr);
        logic [7:0] val;
        val = 8'h00;
        if (offs == `REO_SW_DIS_OFFSET) begin
            val = dis;
        end else if (offs == `REO_OVR_ONE_OFFSET) begin
            val = ovr;
        end
        return val;
    endfunction

    assign rd_data = reg_read(s_q.ptr, s_q.sw_dis, s_q.ovr_one);
    assign rd_next = reg_read(ptr_inc, s_q.sw_dis, s_q.ovr_one);

    // Permit vector: a zero holds the rail off whatever else asks
    always_comb begin
        permit = '0;
        permit[`REO_RAIL_STEP_DOWN_BASE +: 6] = step_down_off_ctl;
        permit[`REO_RAIL_LOW_DROPOUT_A_TWO] = low_dropout_a_two_off_ctl;
        permit[`REO_RAIL_LOAD_SWITCH_A_ONE] = s_q.sw_dis[`REO_DIS_LOAD_SWITCH_A_ONE_BIT];
        permit[`REO_RAIL_LOAD_SWITCH_B_ONE] = s_q.sw_dis[`REO_DIS_LOAD_SWITCH_B_ONE_BIT];
        permit[`REO_RAIL_LOAD_SWITCH_B_TWO] = s_q.sw_dis[`REO_DIS_LOAD_SWITCH_B_TWO_BIT];
        permit[`REO_RAIL_TERM] = s_q.sw_dis[`REO_DIS_TERM_BIT];
    end

    // Force vector: override bits from this bank and from elsewhere
    always_comb begin
        force_on = '0;
        force_on[`REO_RAIL_STEP_DOWN_BASE] = s_q.ovr_one[0];
        force_on[`REO_RAIL_STEP_DOWN_BASE + 1] = s_q.ovr_one[1];
        force_on[`REO_RAIL_STEP_DOWN_BASE + 2] = s_q.ovr_one[2];
        force_on[`REO_RAIL_STEP_DOWN_BASE + 3] = s_q.ovr_one[3];
        force_on[`REO_RAIL_STEP_DOWN_BASE + 4] = s_q.ovr_one[4];
        force_on[`REO_RAIL_STEP_DOWN_BASE + 5] = s_q.ovr_one[5];
        force_on[`REO_RAIL_LOW_DROPOUT_A_TWO] = s_q.ovr_one[`REO_OVR_LOW_DROPOUT_A_TWO_BIT];
        force_on[`REO_RAIL_LOAD_SWITCH_A_ONE] = s_q.ovr_one[`REO_OVR_LOAD_SWITCH_A_ONE_BIT];
        force_on[`REO_RAIL_LOAD_SWITCH_B_ONE] = switch_b_one_force_on;
        force_on[`REO_RAIL_LOAD_SWITCH_B_TWO] = switch_b_two_force_on;
        force_on[`REO_RAIL_TERM] = termination_force_on;
    end

    // One gate per rail; with force low the request decides while permit is high
    for (genvar i = 0; i < `REO_RAIL_COUNT; i++) begin : g_rail
        reo_rail_gate u_gate (
            .permit(permit[i]),
            .force_on(force_on[i]),
            .request(rail_request[i]),
            .enable(gate_out[i])
        );
    end

    // Next state: serial slave, register writes and enable update
    always_comb begin
        s_d = s_q;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        s_d.rail_en = gate_out;

        if (start_seen) begin
            // Start or repeated start: expect an address byte
            s_d.st = REO_ADDR;
            s_d.bit_cnt = `REO_BIT_CNT_ZERO;
            s_d.drive_low = 1'b0;
        end else if (stop_seen) begin
            s_d.st = REO_IDLE;
            s_d.drive_low = 1'b0;
        end else begin
            unique case (s_q.st)
                REO_IDLE: begin
                    s_d.drive_low = 1'b0;
                end
                REO_ADDR: begin
                    if (scl_rise) begin
                        s_d.shift = {s_q.shift[6:0], sda_s};
                        s_d.bit_cnt = s_q.bit_cnt + `REO_BIT_CNT_ONE;
                    end else if (scl_fall && s_q.bit_cnt == `REO_BYTE_BITS) begin
                        if (s_q.shift[7:1] == SLAVE_ADDR) begin
                            s_d.st = REO_ACK_ADDR;
                            s_d.rw = s_q.shift[0];
                            s_d.drive_low = 1'b1;
                        end else begin
                            s_d.st = REO_IDLE;
                        end
                    end
                end
                REO_ACK_ADDR: begin
                    if (scl_fall) begin
                        s_d.bit_cnt = `REO_BIT_CNT_ZERO;
                        if (s_q.rw) begin
                            // Read: present the addressed register msb first
                            s_d.st = REO_RD_BYTE;
                            s_d.shift = rd_data;
                            s_d.drive_low = ~rd_data[7];
                        end else begin
                            s_d.st = REO_WR_BYTE;
                            s_d.first = 1'b1;
                            s_d.drive_low = 1'b0;
                        end
                    end
                end
                REO_WR_BYTE: begin
                    if (scl_rise) begin
                        s_d.shift = {s_q.shift[6:0], sda_s};
                        s_d.bit_cnt = s_q.bit_cnt + `REO_BIT_CNT_ONE;
                    end else if (scl_fall && s_q.bit_cnt == `REO_BYTE_BITS) begin
                        s_d.st = REO_ACK_WR;
                        s_d.drive_low = 1'b1;
                        s_d.first = 1'b0;
                        if (s_q.first) begin
                            s_d.ptr = s_q.shift;
                        end else begin
                            // All eight bits stored; the host keeps 3..0 of the disable register clear
                            if (s_q.ptr == `REO_SW_DIS_OFFSET) begin
                                s_d.sw_dis = s_q.shift;
                            end else if (s_q.ptr == `REO_OVR_ONE_OFFSET) begin
                                s_d.ovr_one = s_q.shift;
                            end
                            s_d.ptr = ptr_inc;
                        end
                    end
                end
                REO_ACK_WR: begin
                    if (scl_fall) begin
                        s_d.st = REO_WR_BYTE;
                        s_d.bit_cnt = `REO_BIT_CNT_ZERO;
                        s_d.drive_low = 1'b0;
                    end
                end
                REO_RD_BYTE: begin
                    if (scl_rise) begin
                        s_d.bit_cnt = s_q.bit_cnt + `REO_BIT_CNT_ONE;
                    end else if (scl_fall) begin
                        if (s_q.bit_cnt == `REO_BYTE_BITS) begin
                            // Release for the host acknowledge
                            s_d.st = REO_ACK_RD;
                            s_d.drive_low = 1'b0;
                        end else begin
                            s_d.shift = {s_q.shift[6:0], 1'b0};
                            s_d.drive_low = ~s_q.shift[6];
                        end
                    end
                end
                REO_ACK_RD: begin
                    if (scl_rise) begin
                        s_d.nack = sda_s;
                    end else if (scl_fall) begin
                        if (s_q.nack) begin
                            // Host ends the read: stay off the bus
                            s_d.st = REO_IDLE;
                        end else begin
                            s_d.st = REO_RD_BYTE;
                            s_d.ptr = ptr_inc;
                            s_d.shift = rd_next;
                            s_d.bit_cnt = `REO_BIT_CNT_ZERO;
                            s_d.drive_low = ~rd_next[7];
                        end
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= TOP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Open-drain pin: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_n = ~s_q.drive_low;

    // Registered rail enables
    assign step_down_one_en = s_q.rail_en[`REO_RAIL_STEP_DOWN_BASE];
    assign step_down_two_en = s_q.rail_en[`REO_RAIL_STEP_DOWN_BASE + 1];
    assign step_down_three_en = s_q.rail_en[`REO_RAIL_STEP_DOWN_BASE + 2];
    assign step_down_four_en = s_q.rail_en[`REO_RAIL_STEP_DOWN_BASE + 3];
    assign step_down_five_en = s_q.rail_en[`REO_RAIL_STEP_DOWN_BASE + 4];
    assign step_down_six_en = s_q.rail_en[`REO_RAIL_STEP_DOWN_BASE + 5];
    assign low_dropout_a_two_en = s_q.rail_en[`REO_RAIL_LOW_DROPOUT_A_TWO];
    assign load_switch_a_one_en = s_q.rail_en[`REO_RAIL_LOAD_SWITCH_A_ONE];
    assign load_switch_b_one_en = s_q.rail_en[`REO_RAIL_LOAD_SWITCH_B_ONE];
    assign load_switch_b_two_en = s_q.rail_en[`REO_RAIL_LOAD_SWITCH_B_TWO];
    assign termination_regulator_en = s_q.rail_en[`REO_RAIL_TERM];
endmodule

//--- bench/reo_asserts.sv
// Checker for the rail enable override bank, bound to reo_top.
// Assumes only the top module's ports; one clock, synchronous reset.
`timescale 1ns/10ps

module reo_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    // Rail controls
    input wire reo_pkg::reo_rail_vec_t rail_request,
    input wire logic [5:0] step_down_off_ctl,
    input wire logic low_dropout_a_two_off_ctl,
    input wire logic switch_b_one_force_on,
    input wire logic switch_b_two_force_on,
    input wire logic termination_force_on,
    // Rail enables
    input wire logic step_down_one_en,
    input wire logic step_down_two_en,
    input wire logic step_down_three_en,
    input wire logic step_down_four_en,
    input wire logic step_down_five_en,
    input wire logic step_down_six_en,
    input wire logic low_dropout_a_two_en,
    input wire logic load_switch_a_one_en,
    input wire logic load_switch_b_one_en,
    input wire logic load_switch_b_two_en,
    input wire logic termination_regulator_en
);
    import reo_pkg::*;
    logic [5:0] sd_en;
    logic [5:0] sd_req;
    logic sw_any;
    // Grouped views of the enables and the permitted requests
    assign sd_en = {step_down_six_en, step_down_five_en, step_down_four_en,
                    step_down_three_en, step_down_two_en, step_down_one_en};
    assign sd_req = rail_request[5:0] & step_down_off_ctl;
    assign sw_any = load_switch_a_one_en | load_switch_b_one_en | load_switch_b_two_en
                    | termination_regulator_en;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    rails_reset_a: assert property (disable iff (1'b0)
        !resetn |=> !sw_any && sd_en == 6'h00 && !low_dropout_a_two_en && sda_oe_n)
        else $error("outputs active after reset");
    sw_start_off_a: assert property (disable iff (1'b0)
        !resetn ##1 resetn |=> !sw_any [*2])
        else $error("switch on with disable bits at reset value");
    sd_block_a: assert property (
        1'b1 |=> (sd_en & ~$past(step_down_off_ctl)) == 6'h00)
        else $error("step-down on while its disable bit is low");
    sd_follow_a: assert property (
        1'b1 |=> (~sd_en & $past(sd_req)) == 6'h00)
        else $error("permitted step-down request not enabled");
    ldo_block_a: assert property (
        !low_dropout_a_two_off_ctl |=> !low_dropout_a_two_en)
        else $error("low-dropout on while disabled");
    ldo_follow_a: assert property (
        low_dropout_a_two_off_ctl && rail_request[6] |=> low_dropout_a_two_en)
        else $error("low-dropout request not enabled");
    swb_idle_a: assert property (
        !rail_request[8] && !switch_b_one_force_on |=> !load_switch_b_one_en)
        else $error("switch b1 on without cause");
    term_idle_a: assert property (
        !rail_request[10] && !termination_force_on |=> !termination_regulator_en)
        else $error("termination on without cause");
    sda_phase_a: assert property (
        $changed(sda_oe_n) |-> !scl_i)
        else $error("data drive moved while scl high");
endmodule

//--- bench/reo_host.sv
// Serial bus host model: drives scl, pulls sda low, reads the wired level.
// Assumes a pull-up on sda; bus half period is ten system clocks.
`timescale 1ns/10ps

module reo_host (
    // Reference clock and wired data
    input wire logic clk,
    input wire logic sda,
    // Bus clock and data pull-down
    output logic scl,
    output logic sda_pull
);
    // Idle bus: clock high and still, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Wait n falling edges
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Start when s is 1, stop when 0: data moves while scl is high
    task automatic mark(input logic s);
        wt(4);
        sda_pull = !s;
        wt(6);
        scl = 1'b1;
        wt(10);
        sda_pull = s;
        wt(10);
        scl = !s;
    endtask

    // One bit: data set in the low phase, level taken as scl falls
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        sda_pull = !b;
        wt(6);
        scl = 1'b1;
        wt(10);
        r = sda;
        scl = 1'b0;
    endtask

    // Byte msb first, then the ninth bit; ack_in is the level seen there
    task automatic xfer(input logic [7:0] tx, input logic ack_out,
                        output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_out, ack_in);
    endtask
endmodule

//--- bench/tb_top.sv
// Testbench: host model on the serial pins, rail inputs set at falling edges,
// readback and enables compared with a local model of the combine.
// Assumes the design files, reo_host and reo_asserts compile first.
`timescale 1ns/10ps
`include "reo_map.svh"

module tb_top;
    import reo_pkg::*;
    localparam logic [6:0] SLV = `REO_SLAVE_ADDR_DEFAULT;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl;
    logic sda_pull;
    logic sda_o;
    logic sda_oe_n;
    reo_rail_vec_t req = '0;
    logic [5:0] sd_off = 6'h3f;
    logic ldo_off = 1'b1;
    logic fb1 = 1'b0;
    logic fb2 = 1'b0;
    logic ft = 1'b0;
    logic [10:0] en;
    logic [7:0] dis_m;
    logic [7:0] ovr_m;
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic ack;
    int err_total = 0;
    int samples_checked = 0;
    // Wired data line with pull-up
    wire logic sda = !(sda_pull || !sda_oe_n);

    // System clock, 8 ns
    always #4 clk = ~clk;

    reo_host host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

    reo_top uut (
        .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .rail_request(req), .step_down_off_ctl(sd_off),
        .low_dropout_a_two_off_ctl(ldo_off), .switch_b_one_force_on(fb1),
        .switch_b_two_force_on(fb2), .termination_force_on(ft),
        .step_down_one_en(en[0]), .step_down_two_en(en[1]), .step_down_three_en(en[2]),
        .step_down_four_en(en[3]), .step_down_five_en(en[4]), .step_down_six_en(en[5]),
        .low_dropout_a_two_en(en[6]), .load_switch_a_one_en(en[7]),
        .load_switch_b_one_en(en[8]), .load_switch_b_two_en(en[9]),
        .termination_regulator_en(en[10])
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [10:0] got, input logic [10:0] want, input string what);
        samples_checked++;
        if (got !== want) begin
            err_total++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    // Expected enables: permit AND (force OR request)
    function automatic logic [10:0] model();
        logic [10:0] p;
        logic [10:0] f;
        p = {dis_m[4], dis_m[7], dis_m[6], dis_m[5], ldo_off, sd_off};
        f = {ft, fb2, fb1, ovr_m[6], ovr_m[7], ovr_m[5:0]};
        return p & (f | req);
    endfunction

    task automatic put_byte(input logic [7:0] d);
        logic [7:0] r;
        host.xfer(d, 1'b1, r, ack);
        chk(11'(ack), 11'h000, "no ack");
    endtask

    task automatic wr2(input logic [7:0] off, input logic [7:0] a, input logic [7:0] b);
        host.mark(1'b1);
        put_byte({SLV, 1'b0});
        put_byte(off);
        put_byte(a);
        put_byte(b);
        host.mark(1'b0);
    endtask

    task automatic rd2(input logic [7:0] off, output logic [7:0] a, output logic [7:0] b);
        logic k;
        host.mark(1'b1);
        put_byte({SLV, 1'b0});
        put_byte(off);
        host.mark(1'b1);
        put_byte({SLV, 1'b1});
        host.xfer(8'hff, 1'b0, a, k);
        host.xfer(8'hff, 1'b1, b, k);
        host.mark(1'b0);
    endtask

    task automatic rd_chk();
        rd2(8'h9f, rd0, rd1);
        chk(11'(rd0), 11'(dis_m), "disable reg");
        chk(11'(rd1), 11'(ovr_m), "override reg");
    endtask

    // Enables under three request patterns
    task automatic sweep();
        logic [10:0] pat [3] = '{11'h7ff, 11'h000, 11'h555};
        foreach (pat[i]) begin
            @(negedge clk);
            req = pat[i];
            repeat (3) @(negedge clk);
            chk(en, model(), "rails");
        end
    endtask

    task automatic apply(input logic [7:0] d, input logic [7:0] o);
        dis_m = d;
        ovr_m = o;
        wr2(8'h9f, d, o);
        rd_chk();
        sweep();
    endtask

    task automatic rst_chk();
        @(negedge clk);
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        dis_m = 8'h00;
        ovr_m = 8'h80;
        repeat (4) @(negedge clk);
        rd_chk();
        sweep();
    endtask

    // Bound on the whole run
    initial begin
        repeat (80000) @(posedge clk);
        err_total++;
        test_done();
    end

    initial begin
        rst_chk();
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            apply(8'hf0, 8'h01 << k);
        end
        $display("test override done");
        for (int k = 4; k < 8; k++) begin
            apply(8'hf0 & ~(8'h01 << k), 8'h40);
        end
        $display("test disable done");
        @(negedge clk);
        sd_off = 6'h2a;
        ldo_off = 1'b0;
        fb1 = 1'b1;
        fb2 = 1'b1;
        ft = 1'b1;
        apply(8'hf0, 8'hff);
        apply(8'h00, 8'hff);
        $display("test mixed done");
        // Outside inputs moved again so each takes both levels while rails run
        @(negedge clk);
        sd_off = 6'h15;
        ldo_off = 1'b1;
        fb1 = 1'b0;
        fb2 = 1'b1;
        ft = 1'b0;
        apply(8'hf0, 8'h00);
        @(negedge clk);
        sd_off = 6'h3f;
        fb1 = 1'b1;
        fb2 = 1'b0;
        ft = 1'b1;
        apply(8'hf0, 8'h80);
        $display("test outside inputs done");
        wr2(8'ha1, 8'hff, 8'hff);
        rd2(8'h9e, rd0, rd1);
        chk(11'(rd0), 11'h000, "unmapped read");
        chk(11'(rd1), 11'(dis_m), "disable after unmapped");
        host.mark(1'b1);
        host.xfer({SLV ^ 7'h01, 1'b0}, 1'b1, rd0, ack);
        chk(11'(ack), 11'h001, "foreign address");
        host.mark(1'b0);
        $display("test refusal done");
        rst_chk();
        $display("test second reset done");
        test_done();
    end
endmodule

bind reo_top reo_asserts chk (
    .clk, .resetn, .scl_i, .sda_i, .sda_o, .sda_oe_n, .rail_request,
    .step_down_off_ctl, .low_dropout_a_two_off_ctl, .switch_b_one_force_on,
    .switch_b_two_force_on, .termination_force_on, .step_down_one_en,
    .step_down_two_en, .step_down_three_en, .step_down_four_en, .step_down_five_en,
    .step_down_six_en, .low_dropout_a_two_en, .load_switch_a_one_en,
    .load_switch_b_one_en, .load_switch_b_two_en, .termination_regulator_en
);
